// ==== logic/adcf_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - past 16th fall, shift newest result out
// - low through 30th fall selects 32-clock mode
// - 32-clock mode pads sixteen zeros next frame
// - host may stop clock after 30th fall
// - power-down request sampled only at select rise
// - conversion ends on resolution-dependent rising edge
// - armed power-down starts at conversion end
// - host stops clock after 32nd fall
// - power-up takes 1us plus acquisition gap
// - burst host raises request before last rise
// - burst host stops clock after 16th fall
// - host keeps 16-clock frames under 30 falls
// - exit power-down on rise with request low
// - sample on select fall, MSB out, shift on falls
// - early select rise keeps 16-clock mode, output floats
// - channel select picks input pair zero or one
module adcf_dev
    import adcf_pkg::*;
#(
    parameter int RES = RES_DEFAULT
) (
    input wire logic clk_i,
    input wire logic srst_i,
    adcf_link_if.dev link,
    input wire logic [RES-1:0] ain0_i,
    input wire logic [RES-1:0] ain1_i,
    output logic conv_done_o,
    output logic [RES-1:0] result_o,
    output logic long_mode_o,
    output logic powered_down_o,
    output logic awake_o
);
    localparam logic [CNT_W-1:0] CONV_EDGE = conv_edge(RES);
    localparam logic [GAP_W-1:0] WAKE_CYC = GAP_W'(PWRUP_CYC);

    // left-justify a result into the serial word
    function automatic logic [WORD_W-1:0] align(input logic [RES-1:0] r);
        align = {r, {(WORD_W-RES){1'b0}}};
    endfunction : align

    // two-stage synchronisers for every pin from the host
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_prev_reg;
    logic sclk_s1_reg;
    logic sclk_s2_reg;
    logic sclk_prev_reg;
    logic pd_s1_reg;
    logic pd_s2_reg;
    logic ch_s1_reg;
    logic ch_s2_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            pd_s1_reg <= 1'b0;
            pd_s2_reg <= 1'b0;
            ch_s1_reg <= 1'b0;
            ch_s2_reg <= 1'b0;
        end else begin
            cs_s1_reg <= link.cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_prev_reg <= cs_s2_reg;
            sclk_s1_reg <= link.sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_prev_reg <= sclk_s2_reg;
            pd_s1_reg <= link.power_down_request;
            pd_s2_reg <= pd_s1_reg;
            ch_s1_reg <= link.channel_select;
            ch_s2_reg <= ch_s1_reg;
        end
    end

    // edge detection on the synchronised pins
    wire logic cs_fall = cs_prev_reg & ~cs_s2_reg;
    wire logic cs_rise = ~cs_prev_reg & cs_s2_reg;
    wire logic sclk_rise = ~cs_s2_reg & ~sclk_prev_reg & sclk_s2_reg;
    wire logic sclk_fall = ~cs_s2_reg & sclk_prev_reg & ~sclk_s2_reg;

    // frame edge counters, saturating so long frames cannot wrap
    logic [CNT_W-1:0] rise_cnt_reg;
    logic [CNT_W-1:0] fall_cnt_reg;
    wire logic [CNT_W-1:0] rise_cnt_next = (rise_cnt_reg == CNT_MAX) ? CNT_MAX
                                           : rise_cnt_reg + 1'b1;
    wire logic [CNT_W-1:0] fall_cnt_next = (fall_cnt_reg == CNT_MAX) ? CNT_MAX
                                           : fall_cnt_reg + 1'b1;
    // a fall counts only once the first rise of the frame was seen
    wire logic shift_fall = sclk_fall & (rise_cnt_reg != '0);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rise_cnt_reg <= '0;
            fall_cnt_reg <= '0;
        end else if (cs_fall) begin
            rise_cnt_reg <= '0;
            fall_cnt_reg <= '0;
        end else begin
            if (sclk_rise) begin
                rise_cnt_reg <= rise_cnt_next;
            end
            if (shift_fall) begin
                fall_cnt_reg <= fall_cnt_next;
            end
        end
    end

    // sample capture and conversion end
    logic [RES-1:0] sample_reg;
    logic [RES-1:0] result_reg;
    logic conv_done_reg;
    wire logic conv_end = sclk_rise & (rise_cnt_next == CONV_EDGE);
    wire logic [RES-1:0] picked = ch_s2_reg ? ain1_i : ain0_i;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sample_reg <= '0;
            result_reg <= '0;
            conv_done_reg <= 1'b0;
        end else begin
            conv_done_reg <= conv_end & (rise_cnt_reg != CONV_EDGE);
            if (cs_fall) begin
                sample_reg <= picked;
            end
            if (conv_end & (rise_cnt_reg != CONV_EDGE)) begin
                result_reg <= sample_reg;
            end
        end
    end

    // frame mode: detected at the 30th fall, cleared by an early rise
    logic long_mode_reg;
    wire logic long_detect = shift_fall & (fall_cnt_next == LONG_DETECT_EDGE);
    wire logic short_keep = cs_rise & (fall_cnt_reg < SHORT_MAX_EDGES);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            long_mode_reg <= 1'b0;
        end else if (long_detect) begin
            long_mode_reg <= 1'b1;
        end else if (short_keep) begin
            long_mode_reg <= 1'b0;
        end
    end

    // serial output shifter
    logic [WORD_W-1:0] shift_reg;
    wire logic load_result = shift_fall & (fall_cnt_next == RESULT_LOAD_EDGE);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            shift_reg <= '0;
        end else if (cs_fall) begin
            // zeros after a long frame, else the previous result
            shift_reg <= long_mode_reg ? '0 : align(result_reg);
        end else if (load_result) begin
            shift_reg <= align(result_reg);
        end else if (shift_fall) begin
            shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
        end
    end

    // power-down arming, entry and exit
    logic pd_armed_reg;
    logic powered_down_reg;
    wire logic pd_exit = cs_rise & ~pd_s2_reg & powered_down_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pd_armed_reg <= 1'b0;
            powered_down_reg <= 1'b0;
        end else begin
            if (cs_rise) begin
                pd_armed_reg <= pd_s2_reg;
            end
            if (pd_exit) begin
                powered_down_reg <= 1'b0;
            end else if (conv_end & pd_armed_reg & ~cs_s2_reg) begin
                powered_down_reg <= 1'b1;
            end
        end
    end

    // power-up delay after leaving power-down
    logic [GAP_W-1:0] wake_cnt_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wake_cnt_reg <= '0;
        end else if (pd_exit) begin
            wake_cnt_reg <= WAKE_CYC;
        end else if (wake_cnt_reg != '0) begin
            wake_cnt_reg <= wake_cnt_reg - 1'b1;
        end
    end

    // pin and user outputs
    assign link.sdo_d = shift_reg[WORD_W-1];
    assign link.sdo_oe = ~cs_s2_reg;
    assign conv_done_o = conv_done_reg;
    assign result_o = result_reg;
    assign long_mode_o = long_mode_reg;
    assign powered_down_o = powered_down_reg;
    assign awake_o = ~powered_down_reg & (wake_cnt_reg == '0);
endmodule : adcf_dev
`default_nettype wire

// ==== logic/adcf_pkg.sv ====
`default_nettype none
package adcf_pkg;
    // frame geometry, counted in serial clock edges
    localparam int WORD_W = 16;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] SHORT_FRAME_EDGES = 6'd16;
    localparam logic [CNT_W-1:0] RESULT_LOAD_EDGE = 6'd16;
    localparam logic [CNT_W-1:0] LONG_DETECT_EDGE = 6'd30;
    localparam logic [CNT_W-1:0] SHORT_MAX_EDGES = 6'd29;
    localparam logic [CNT_W-1:0] LONG_FRAME_EDGES = 6'd32;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'd63;
    localparam int RES_DEFAULT = 12;

    // timing of the power-up and acquisition windows
    localparam int CLK_MHZ = 100;
    localparam int PWRUP_NS = 1000;
    localparam int ACQ_MIN_NS = 80;
    localparam int PWRUP_CYC = (PWRUP_NS * CLK_MHZ + 999) / 1000;
    localparam int ACQ_CYC = (ACQ_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_W = 8;
    localparam int HALF_DEFAULT = 8;

    // host sequencer states
    typedef enum logic [2:0] {
        ADCF_IDLE,
        ADCF_LEAD,
        ADCF_HIGH,
        ADCF_LOW,
        ADCF_GAP
    } adcf_host_state_t;

    // rising edge on which conversion ends, per resolution
    function automatic logic [CNT_W-1:0] conv_edge(input int res);
        unique case (res)
            10: conv_edge = 6'd11;
            8: conv_edge = 6'd9;
            default: conv_edge = 6'd14;
        endcase
    endfunction : conv_edge
endpackage : adcf_pkg
`default_nettype wire

// ==== logic/adcf_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface adcf_link_if;
    logic cs_n;
    logic sclk;
    logic power_down_request;
    logic channel_select;
    logic sdo_d;
    logic sdo_oe;
    logic sdo;

    // resolved serial data wire, pulled high while floating
    assign sdo = sdo_oe ? sdo_d : 1'b1;

    modport dev (
        input cs_n,
        input sclk,
        input power_down_request,
        input channel_select,
        output sdo_d,
        output sdo_oe
    );
    modport host (
        output cs_n,
        output sclk,
        output power_down_request,
        output channel_select,
        input sdo
    );
endinterface : adcf_link_if
`default_nettype wire

// ==== logic/adcf_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcf_host
    import adcf_pkg::*;
#(
    parameter int HALF = HALF_DEFAULT
) (
    input wire logic clk_i,
    input wire logic srst_i,
    adcf_link_if.host link,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_long_i,
    input wire logic req_pd_i,
    input wire logic req_ch_i,
    output logic word_valid_o,
    input wire logic word_ready_i,
    output logic [WORD_W-1:0] word_o
);
    localparam logic [GAP_W-1:0] HALF_CYC = GAP_W'(HALF);
    localparam logic [GAP_W-1:0] GAP_SHORT = GAP_W'(ACQ_CYC);
    localparam logic [GAP_W-1:0] GAP_LONG = GAP_W'(PWRUP_CYC + ACQ_CYC);

    // serial data synchroniser
    logic sdo_s1_reg;
    logic sdo_s2_reg;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sdo_s1_reg <= 1'b1;
            sdo_s2_reg <= 1'b1;
        end else begin
            sdo_s1_reg <= link.sdo;
            sdo_s2_reg <= sdo_s1_reg;
        end
    end

    // two-entry result buffer
    logic [WORD_W-1:0] shift_in_reg;
    logic [WORD_W-1:0] mem [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] fill_reg;
    logic push;
    wire logic pop = word_valid_o & word_ready_i;
    assign word_valid_o = (fill_reg != 2'd0);
    assign word_o = mem[rd_ptr_reg];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            fill_reg <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            fill_reg <= fill_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= shift_in_reg;
        end
    end

    // frame sequencer
    adcf_host_state_t state_reg;
    logic cs_n_reg;
    logic sclk_reg;
    logic pd_reg;
    logic ch_reg;
    logic long_reg;
    logic [GAP_W-1:0] div_reg;
    logic [CNT_W-1:0] edge_reg;
    logic pd_last_reg;

    // a frame starts only while the buffer can take its word
    assign req_ready_o = (state_reg == ADCF_IDLE) & (fill_reg != 2'd2);
    wire logic take = req_valid_i & req_ready_o;
    wire logic half_done = (div_reg == HALF_CYC - 1'b1);
    // 32 edges for long frames, 16 otherwise
    wire logic [CNT_W-1:0] frame_edges = long_reg ? LONG_FRAME_EDGES
                                         : SHORT_FRAME_EDGES;
    wire logic last_edge = (edge_reg == frame_edges);
    assign push = (state_reg == ADCF_LOW) & half_done & last_edge;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= ADCF_IDLE;
            cs_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
            pd_reg <= 1'b0;
            pd_last_reg <= 1'b0;
            ch_reg <= 1'b0;
            long_reg <= 1'b0;
            div_reg <= '0;
            edge_reg <= '0;
            shift_in_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
            unique case (state_reg)
                ADCF_IDLE: begin
                    if (take) begin
                        long_reg <= req_long_i;
                        pd_last_reg <= pd_reg;
                        pd_reg <= req_pd_i;
                        ch_reg <= req_ch_i;
                        cs_n_reg <= 1'b0;
                        edge_reg <= '0;
                        div_reg <= '0;
                        state_reg <= ADCF_LEAD;
                    end
                end
                ADCF_LEAD: begin
                    if (half_done) begin
                        sclk_reg <= 1'b1;
                        div_reg <= '0;
                        state_reg <= ADCF_HIGH;
                    end
                end
                ADCF_HIGH: begin
                    if (half_done) begin
                        // sample just before the falling edge
                        shift_in_reg <= {shift_in_reg[WORD_W-2:0], sdo_s2_reg};
                        sclk_reg <= 1'b0;
                        edge_reg <= edge_reg + 1'b1;
                        div_reg <= '0;
                        state_reg <= ADCF_LOW;
                    end
                end
                ADCF_LOW: begin
                    if (half_done & last_edge) begin
                        cs_n_reg <= 1'b1;
                        div_reg <= '0;
                        state_reg <= ADCF_GAP;
                    end else if (half_done) begin
                        sclk_reg <= 1'b1;
                        div_reg <= '0;
                        state_reg <= ADCF_HIGH;
                    end
                end
                ADCF_GAP: begin
                    // longer select-high time after a power-down frame and the wake frame
                    if (div_reg == ((pd_reg | pd_last_reg) ? GAP_LONG : GAP_SHORT)) begin
                        state_reg <= ADCF_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_reg;
    assign link.sclk = sclk_reg;
    assign link.power_down_request = pd_reg;
    assign link.channel_select = ch_reg;
endmodule : adcf_host
`default_nettype wire

// ==== tb/adcf_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcf_chk
    import adcf_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic power_down_request,
    input wire logic channel_select,
    input wire logic sdo_d,
    input wire logic sdo_oe
);
    logic [CNT_W-1:0] fall_cnt_reg;
    logic [7:0] since_fall_reg;
    logic [7:0] since_csf_reg;
    logic [7:0] high_cnt_reg;
    logic sclk_q_reg;
    logic cs_q_reg;
    logic long_prev_reg;
    logic pd_at_rise_reg;
    logic pd_before_reg;
    wire logic sclk_fall = sclk_q_reg & ~sclk;
    wire logic cs_rise = cs_n & ~cs_q_reg;
    wire logic cs_fall = ~cs_n & cs_q_reg;

    function automatic logic [7:0] sat(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction : sat

    // pin history, so edges are seen at the raw pins, ahead of the device's synchronisers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sclk_q_reg <= 1'b0;
            cs_q_reg <= 1'b1;
        end else begin
            sclk_q_reg <= sclk;
            cs_q_reg <= cs_n;
        end
    end

    // clock falls counted while selected
    always_ff @(posedge clk_i) begin
        if (srst_i || cs_n) begin
            fall_cnt_reg <= '0;
        end else if (sclk_fall && fall_cnt_reg != CNT_MAX) begin
            fall_cnt_reg <= fall_cnt_reg + 6'h01;
        end
    end

    // frame mode and power request as left by the last select rise
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            long_prev_reg <= 1'b0;
            pd_at_rise_reg <= 1'b0;
            pd_before_reg <= 1'b0;
        end else if (cs_rise) begin
            pd_at_rise_reg <= power_down_request;
            pd_before_reg <= pd_at_rise_reg;
            if (fall_cnt_reg >= LONG_DETECT_EDGE) begin
                long_prev_reg <= 1'b1;
            end else if (fall_cnt_reg < SHORT_MAX_EDGES) begin
                long_prev_reg <= 1'b0;
            end
        end
    end

    // cycles since clock fall, select fall and select rise
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            since_fall_reg <= 8'hff;
            since_csf_reg <= 8'hff;
            high_cnt_reg <= 8'hff;
        end else begin
            since_fall_reg <= sclk_fall ? 8'h00 : sat(since_fall_reg);
            since_csf_reg <= cs_fall ? 8'h00 : sat(since_csf_reg);
            high_cnt_reg <= cs_n ? sat(high_cnt_reg) : 8'h00;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    // frame opening: select falls, output turns on, clock rests low
    sequence s_open;
        $fell(cs_n);
    endsequence
    sequence s_drive;
        ##[1:6] sdo_oe;
    endsequence
    sequence s_lead;
        !sclk [*4];
    endsequence

    AST_OE_ON: assert property (s_open |-> s_drive)
        else $error("data output not driven after select fall");
    AST_LEAD_LOW: assert property (s_open |-> s_lead)
        else $error("clock not low at frame start");
    AST_OE_OFF: assert property ($rose(cs_n) |-> ##[1:6] !sdo_oe)
        else $error("data output still driven after select rise");
    AST_SHIFT_ON_FALL: assert property (!cs_n && sdo_oe && $past(sdo_oe) && $changed(sdo_d)
        |-> since_fall_reg < 8'h08 || since_csf_reg < 8'h0c)
        else $error("data bit changed away from a clock fall");
    AST_ZERO_PAD: assert property ($rose(sclk) && !cs_n && long_prev_reg
        && fall_cnt_reg < SHORT_FRAME_EDGES |-> sdo_d == 1'b0)
        else $error("nonzero bit in padding after long frame");
    AST_FRAME_LEN: assert property ($rose(cs_n)
        |-> fall_cnt_reg == SHORT_FRAME_EDGES || fall_cnt_reg == LONG_FRAME_EDGES)
        else $error("frame ended with wrong fall count");
    AST_PD_HOLD: assert property (!cs_n && !$past(cs_n) |-> $stable(power_down_request))
        else $error("power request moved inside frame");
    AST_CH_HOLD: assert property (!cs_n && !$past(cs_n) |-> $stable(channel_select))
        else $error("channel moved inside frame");
    AST_SCLK_REST: assert property (cs_n && $past(cs_n) |-> !sclk)
        else $error("clock running while deselected");
    AST_PWRUP_GAP: assert property ($fell(cs_n)
        |-> high_cnt_reg >= ((pd_at_rise_reg || pd_before_reg) ? PWRUP_CYC + ACQ_CYC : ACQ_CYC))
        else $error("select high time too short");
endmodule : adcf_chk
`default_nettype wire

// ==== tb/test_adc_serial_frame_powerdown.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) report(32'(a), 32'(e)); end
module test_adc_serial_frame_powerdown;
    logic clk_i;
    logic srst_i;
    logic req_valid;
    logic req_ready;
    logic req_long;
    logic req_pd;
    logic req_ch;
    logic word_valid;
    logic word_ready;
    logic [15:0] word;
    logic [11:0] ain0_a;
    logic [11:0] ain1_a;
    logic [7:0] ain0_b;
    logic [7:0] ain1_b;
    logic [7:0] res_b;
    logic long_a;
    logic long_b;
    logic pd_b;
    logic awake_b;
    logic done_b;
    logic pd_early;
    logic pd_late;
    logic [31:0] cap;
    int done_at;
    int bad_count = 0;
    int n_checks = 0;

    adcf_link_if link_a();
    adcf_link_if link_b();

    // host and device joined on the main link
    adcf_dev #(.RES(12)) i_adcf_dev (
        .clk_i(clk_i), .srst_i(srst_i), .link(link_a), .ain0_i(ain0_a), .ain1_i(ain1_a),
        .conv_done_o(), .result_o(), .long_mode_o(long_a), .powered_down_o(), .awake_o()
    );
    adcf_host #(.HALF(8)) i_adcf_host (
        .clk_i(clk_i), .srst_i(srst_i), .link(link_a), .req_valid_i(req_valid),
        .req_ready_o(req_ready), .req_long_i(req_long), .req_pd_i(req_pd), .req_ch_i(req_ch),
        .word_valid_o(word_valid), .word_ready_i(word_ready), .word_o(word)
    );
    // second device driven pin by pin, frames of any length
    adcf_dev #(.RES(8)) i_adcf_dev_b (
        .clk_i(clk_i), .srst_i(srst_i), .link(link_b), .ain0_i(ain0_b), .ain1_i(ain1_b),
        .conv_done_o(done_b), .result_o(res_b), .long_mode_o(long_b),
        .powered_down_o(pd_b), .awake_o(awake_b)
    );
    adcf_chk i_adcf_chk (
        .clk_i(clk_i), .srst_i(srst_i), .cs_n(link_a.cs_n), .sclk(link_a.sclk),
        .power_down_request(link_a.power_down_request),
        .channel_select(link_a.channel_select), .sdo_d(link_a.sdo_d), .sdo_oe(link_a.sdo_oe)
    );

    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        bad_count++;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    endtask : report

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // one conversion request on the host's user side
    task automatic req(input logic lng, input logic pd, input logic ch);
        int t;
        t = 0;
        while (req_ready !== 1'b1 && t < 2000) begin
            @(negedge clk_i);
            t++;
        end
        if (t == 2000) bad_count++;
        req_valid = 1'b1;
        req_long = lng;
        req_pd = pd;
        req_ch = ch;
        @(negedge clk_i);
        req_valid = 1'b0;
    endtask : req

    // take one word from the host buffer and compare it
    task automatic pop(input logic [15:0] exp);
        int t;
        t = 0;
        // one edge passes so word_ready never rises where the last pop dropped it
        @(negedge clk_i);
        while (word_valid !== 1'b1 && t < 2000) begin
            @(negedge clk_i);
            t++;
        end
        if (t == 2000) bad_count++;
        `CHK(word, exp)
        word_ready = 1'b1;
        @(negedge clk_i);
        word_ready = 1'b0;
    endtask : pop

    // half clock period, noting which rise ended conversion
    task automatic wait8(input int k);
        repeat (8) begin
            @(negedge clk_i);
            if (done_b === 1'b1) done_at = k;
        end
    endtask : wait8

    // bit-banged frame of n clocks; pdm held inside, pde at the rise
    task automatic frame(input int n, input logic pdm, input logic pde, input logic ch);
        cap = '0;
        done_at = 0;
        link_b.cs_n = 1'b0;
        link_b.channel_select = ch;
        link_b.power_down_request = pdm;
        wait8(0);
        for (int k = 1; k <= n; k++) begin
            link_b.sclk = 1'b1;
            wait8(k);
            if (k == 2) pd_early = pd_b;
            cap = {cap[30:0], link_b.sdo};
            link_b.sclk = 1'b0;
            wait8(k);
        end
        pd_late = pd_b;
        link_b.power_down_request = pde;
        @(negedge clk_i);
        link_b.cs_n = 1'b1;
        repeat (20) @(negedge clk_i);
    endtask : frame

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        wrap_up();
    end

    initial begin
        srst_i = 1'b1;
        {req_valid, req_long, req_pd, req_ch, word_ready} = 5'h00;
        ain0_a = 12'h09c3;
        ain1_a = 12'h05a6;
        ain0_b = 8'ha5;
        ain1_b = 8'h3c;
        link_b.cs_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.power_down_request = 1'b0;
        link_b.channel_select = 1'b0;
        repeat (5) @(negedge clk_i);
        srst_i = 1'b0;
        // main link: short, long, buffer full, padding, power-down
        req(1'b0, 1'b0, 1'b0);
        pop(16'h0000);
        req(1'b0, 1'b0, 1'b1);
        pop(16'h9c30);
        req(1'b1, 1'b0, 1'b1);
        req(1'b1, 1'b0, 1'b0);
        repeat (800) @(negedge clk_i);
        `CHK(req_ready, 1'b0)
        `CHK(long_a, 1'b1)
        pop(16'h5a60);
        pop(16'h9c30);
        req(1'b0, 1'b0, 1'b1);
        pop(16'h0000);
        // the device sees the select rise a few cycles after the word lands
        repeat (4) @(negedge clk_i);
        `CHK(long_a, 1'b0)
        req(1'b0, 1'b1, 1'b0);
        req(1'b0, 1'b0, 1'b0);
        pop(16'h5a60);
        pop(16'h9c30);
        // first frame after wake needs the long select-high gap
        req(1'b0, 1'b0, 1'b1);
        pop(16'h9c30);
        // pin-level device: counts, boundaries, power-down
        frame(16, 1'b0, 1'b0, 1'b0);
        `CHK(done_at, 9)
        `CHK(res_b, 8'ha5)
        `CHK(link_b.sdo, 1'b1)
        frame(29, 1'b0, 1'b0, 1'b1);
        `CHK(cap[28:5], 24'ha5_003c)
        `CHK(long_b, 1'b0)
        frame(30, 1'b0, 1'b0, 1'b0);
        `CHK(cap[29:14], 16'h3c00)
        `CHK(long_b, 1'b1)
        frame(32, 1'b0, 1'b0, 1'b1);
        `CHK(cap, 32'h0000_3c00)
        frame(16, 1'b0, 1'b0, 1'b0);
        `CHK(cap[15:0], 16'h0000)
        `CHK(long_b, 1'b0)
        frame(16, 1'b1, 1'b1, 1'b0);
        `CHK(pd_b, 1'b0)
        frame(16, 1'b1, 1'b0, 1'b0);
        `CHK(pd_early, 1'b0)
        `CHK(pd_late, 1'b1)
        `CHK(cap[15:0], 16'ha500)
        `CHK(pd_b, 1'b0)
        `CHK(awake_b, 1'b0)
        repeat (100) @(negedge clk_i);
        `CHK(awake_b, 1'b1)
        frame(16, 1'b1, 1'b0, 1'b1);
        `CHK(pd_late, 1'b0)
        wrap_up();
    end
endmodule : test_adc_serial_frame_powerdown
`default_nettype wire
